// [logic/cwl_line_control.sv]
`timescale 1ns/10ps
module cwl_line_control
  import cwl_pkg::*;
#(
  parameter int MODE_DLY = CWL_MODE_DLY_CYC,
  parameter int DOM_TO = CWL_DOM_TO_CYC,
  parameter int FILT_MAX = CWL_FILT_MAX_CYC,
  parameter int WAKE_TO = CWL_WAKE_TO_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic canTx,
  output logic canRx,
  input wire logic busDominant,
  input wire logic wakeBusDominant,
  output logic drvDominant,
  output logic [1:0] slewSel,
  output logic busWake,
  output logic irq
);
  typedef struct packed {
    logic [1:0] mode;
    logic wakeEn;
    logic [1:0] slew;
    cwl_state_t st;
    logic [15:0] dly;
    logic [15:0] domCnt;
    logic domLock;
    logic wakeFlag;
    logic [CWL_IRQ_W-1:0] status;
    logic [CWL_IRQ_W-1:0] mask;
    logic dPend;
    logic dWrite;
    logic [7:0] dAddr;
    logic [31:0] rdata;
    logic rx;
    logic drv;
    logic irqOut;
    logic ready;
    logic resp;
  } cwl_top_t;
  cwl_top_t s;
  cwl_top_t next_s;
  logic wakeEvent;
  logic canActive;
  logic [31:0] ctrlWord;

  function automatic logic [31:0] regRead(input logic [7:0] a, input cwl_top_t c, input logic [31:0] cw);
    if (a == CWL_OFF_CTRL) begin
      return cw;
    end else if (a == CWL_OFF_STAT) begin
      return {29'h0, c.domLock, c.st == CWL_ST_ACTIVE, c.wakeFlag};
    end else if (a == CWL_OFF_IRQ) begin
      return {29'h0, c.status};
    end else if (a == CWL_OFF_MASK) begin
      return {29'h0, c.mask};
    end else begin
      return 32'h0000_0000;
    end
  endfunction

  cwl_wake_detect #(
    .FILT_MAX(FILT_MAX),
    .WAKE_TO(WAKE_TO)
  ) uWake (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(s.wakeEn && s.st == CWL_ST_LOWPWR && !s.wakeFlag),
    .busDominant(wakeBusDominant),
    .wakeEvent(wakeEvent)
  );

  assign canActive = (s.st == CWL_ST_ACTIVE);
  assign ctrlWord = {26'h0, s.slew, 1'b0, s.wakeEn, s.mode};
  assign hrdata = s.rdata;
  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign canRx = s.rx;
  assign drvDominant = s.drv;
  assign slewSel = s.slew;
  assign busWake = s.wakeFlag;
  assign irq = s.irqOut;

  always_comb begin
    logic [CWL_IRQ_W-1:0] ev;
    logic rdIrq;
    ev = '0;
    rdIrq = 1'b0;
    next_s = s;
    // zero wait state, every transfer answered okay
    next_s.ready = 1'b1;
    next_s.resp = 1'b0;
    // address phase capture
    next_s.dPend = 1'b0;
    if (hready && hsel && htrans[1]) begin
      next_s.dPend = 1'b1;
      next_s.dWrite = hwrite;
      next_s.dAddr = haddr[7:0];
      if (!hwrite) begin
        next_s.rdata = regRead(haddr[7:0], s, ctrlWord);
        rdIrq = (haddr[7:0] == CWL_OFF_IRQ);
      end
    end
    // data phase write
    if (s.dPend && s.dWrite) begin
      if (s.dAddr == CWL_OFF_CTRL) begin
        next_s.mode = hwdata[CWL_CTRL_MODE_LSB +: 2];
        next_s.wakeEn = hwdata[CWL_CTRL_WAKEEN_BIT];
        next_s.slew = hwdata[CWL_CTRL_SLEW_LSB +: 2];
      end else if (s.dAddr == CWL_OFF_MASK) begin
        next_s.mask = hwdata[CWL_IRQ_W-1:0];
      end
    end
    // mode state machine
    case (s.st)
      CWL_ST_LOWPWR: begin
        if (s.mode == CWL_MODE_NORMAL) begin
          next_s.st = CWL_ST_SWITCH;
          next_s.dly = 16'h0000;
        end
      end
      CWL_ST_SWITCH: begin
        next_s.dly = s.dly + 16'h0001;
        if (s.mode != CWL_MODE_NORMAL) begin
          next_s.st = CWL_ST_LOWPWR;
        end else if (s.dly >= 16'(MODE_DLY - 2)) begin
          next_s.st = CWL_ST_ACTIVE;
          ev[CWL_IRQ_MODE_BIT] = 1'b1;
        end
      end
      CWL_ST_ACTIVE: begin
        if (s.mode != CWL_MODE_NORMAL) begin
          next_s.st = CWL_ST_LOWPWR;
        end
      end
      default: begin
        next_s.st = CWL_ST_LOWPWR;
      end
    endcase
    if (canActive) begin
      next_s.wakeFlag = 1'b0;
    end
    if (wakeEvent) begin
      next_s.wakeFlag = 1'b1;
      ev[CWL_IRQ_WAKE_BIT] = 1'b1;
    end
    if (!canActive || canTx) begin
      next_s.domCnt = 16'h0000;
      next_s.domLock = 1'b0;
    end else if (!s.domLock) begin
      next_s.domCnt = s.domCnt + 16'h0001;
      if (s.domCnt >= 16'(DOM_TO - 1)) begin
        next_s.domLock = 1'b1;
        ev[CWL_IRQ_DOMTO_BIT] = 1'b1;
      end
    end
    next_s.drv = canActive && !canTx && !next_s.domLock;
    // rx reports bus, recessive when idle
    next_s.rx = canActive ? !busDominant : 1'b1;
    // set wins over read-clear
    next_s.status = (rdIrq ? '0 : s.status) | ev;
    next_s.irqOut = |(next_s.status & s.mask);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= CWL_ST_LOWPWR;
      s.wakeEn <= CWL_CTRL_RESET[CWL_CTRL_WAKEEN_BIT];
      s.rx <= 1'b1;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [logic/cwl_pkg.sv]
package cwl_pkg;
  // register byte offsets
  localparam logic [7:0] CWL_OFF_CTRL = 8'h00;
  localparam logic [7:0] CWL_OFF_STAT = 8'h04;
  localparam logic [7:0] CWL_OFF_IRQ = 8'h08;
  localparam logic [7:0] CWL_OFF_MASK = 8'h0c;
  // control fields
  localparam int CWL_CTRL_MODE_LSB = 0;
  localparam int CWL_CTRL_WAKEEN_BIT = 2;
  localparam int CWL_CTRL_SLEW_LSB = 4;
  localparam logic [31:0] CWL_CTRL_RESET = 32'h0000_0004;
  // interrupt bits
  localparam int CWL_IRQ_WAKE_BIT = 0;
  localparam int CWL_IRQ_DOMTO_BIT = 1;
  localparam int CWL_IRQ_MODE_BIT = 2;
  localparam int CWL_IRQ_W = 3;
  // clock and timing
  localparam int CWL_CLK_KHZ = 25000;
  localparam int CWL_FILT_MIN_NS = 500;
  localparam int CWL_FILT_MAX_US = 500;
  localparam int CWL_WAKE_TO_US = 500;
  localparam int CWL_MODE_DLY_US = 10;
  localparam int CWL_DOM_TO_US = 360;
  localparam int CWL_WAKE_PULSES = 3;
  // least width rounds up, longest times round down
  localparam int CWL_FILT_MIN_CYC = (CWL_FILT_MIN_NS * CWL_CLK_KHZ + 999999) / 1000000;
  localparam int CWL_FILT_MAX_CYC = CWL_FILT_MAX_US * CWL_CLK_KHZ / 1000;
  localparam int CWL_WAKE_TO_CYC = CWL_WAKE_TO_US * CWL_CLK_KHZ / 1000;
  localparam int CWL_MODE_DLY_CYC = CWL_MODE_DLY_US * CWL_CLK_KHZ / 1000;
  localparam int CWL_DOM_TO_CYC = CWL_DOM_TO_US * CWL_CLK_KHZ / 1000;
  typedef enum logic [1:0] {
    CWL_MODE_SLEEP = 2'h0,
    CWL_MODE_STANDBY = 2'h1,
    CWL_MODE_NORMAL = 2'h2,
    CWL_MODE_STOP = 2'h3
  } cwl_mode_t;
  typedef enum logic [2:0] {
    CWL_ST_LOWPWR = 3'h1,
    CWL_ST_SWITCH = 3'h2,
    CWL_ST_ACTIVE = 3'h4
  } cwl_state_t;
endpackage

// [logic/cwl_wake_detect.sv]
`timescale 1ns/10ps
module cwl_wake_detect
  import cwl_pkg::*;
#(
  parameter int FILT_MAX = CWL_FILT_MAX_CYC,
  parameter int WAKE_TO = CWL_WAKE_TO_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic busDominant,
  output logic wakeEvent
);
  typedef struct packed {
    logic [15:0] width;
    logic [15:0] gap;
    logic [1:0] count;
    logic prevDom;
    logic gapRun;
    logic wake;
  } cwl_wd_t;
  cwl_wd_t s;
  cwl_wd_t next_s;
  assign wakeEvent = s.wake;
  always_comb begin
    next_s = s;
    next_s.wake = 1'b0;
    next_s.prevDom = busDominant;
    if (!enable) begin
      next_s.count = 2'h0;
      next_s.gapRun = 1'b0;
      next_s.width = 16'h0000;
    end else begin
      if (busDominant && s.width != 16'hffff) begin
        next_s.width = s.width + 16'h0001;
      end
      if (s.gapRun && s.gap != 16'hffff) begin
        next_s.gap = s.gap + 16'h0001;
      end
      if (s.gapRun && s.gap >= 16'(WAKE_TO)) begin
        next_s.count = 2'h0;
        next_s.gapRun = 1'b0;
      end
      if (s.prevDom && !busDominant) begin
        next_s.width = 16'h0000;
        if (s.width >= 16'(CWL_FILT_MIN_CYC) && s.width < 16'(FILT_MAX)) begin
          if (s.count == 2'(CWL_WAKE_PULSES - 1)) begin
            next_s.wake = 1'b1;
            next_s.count = 2'h0;
            next_s.gapRun = 1'b0;
          end else begin
            next_s.count = s.count + 2'h1;
            next_s.gapRun = 1'b1;
            next_s.gap = 16'h0000;
          end
        end else begin
          next_s.count = 2'h0;
          next_s.gapRun = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [bench/cwl_bus_model.sv]
`timescale 1ns/10ps
module cwl_bus_model (
  input wire logic drvDominant,
  input wire logic extDom,
  output logic busDominant,
  output logic wakeBusDominant
);
  // wired bus, any dominant driver wins
  assign busDominant = drvDominant | extDom;
  // wake receiver sees the same line
  assign wakeBusDominant = busDominant;
endmodule

// [bench/cwl_line_checker.sv]
`timescale 1ns/10ps
module cwl_line_checker
  import cwl_pkg::*;
#(
  parameter int DOM_TO = CWL_DOM_TO_CYC,
  parameter int MODE_DLY = CWL_MODE_DLY_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  input wire logic canTx,
  input wire logic canRx,
  input wire logic busDominant,
  input wire logic drvDominant,
  input wire logic [1:0] slewSel,
  input wire logic busWake
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // outputs are registered once more after the mode switch completes
  localparam int MODE_WIN = MODE_DLY + 2;
  int lowCnt;
  int sinceWr;
  logic ctrlWr;
  assign ctrlWr = hsel && hready && htrans[1] && hwrite && haddr[7:0] == CWL_OFF_CTRL;
  // sinceWr saturates at 999 so a long idle stretch cannot wrap; lowCnt does not saturate
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt <= 0;
      sinceWr <= 999;
    end else begin
      // starts at the first dominant drive, tx held low outside active mode does not count
      lowCnt <= canTx ? 0 : ((lowCnt != 0 || drvDominant) ? lowCnt + 1 : 0);
      sinceWr <= ctrlWr ? 0 : (sinceWr < 999 ? sinceWr + 1 : 999);
    end
  end
  sequence s_normWr;
    ctrlWr ##1 hwdata[1:0] == CWL_MODE_NORMAL;
  endsequence
  sequence s_lowWr;
    ctrlWr ##1 hwdata[1:0] != CWL_MODE_NORMAL;
  endsequence
  a_mode_delay: assert property (s_normWr |-> ##MODE_WIN (canRx == !$past(busDominant)))
    else $error("normal mode late");
  a_dom_release: assert property (lowCnt > DOM_TO + 2 |-> !drvDominant)
    else $error("dominant not released");
  a_tx_recessive: assert property ($past(canTx) |-> !drvDominant)
    else $error("drive while tx high");
  a_rx_recessive: assert property (!$past(busDominant) |-> canRx)
    else $error("rx low on idle bus");
  a_wake_idle: assert property ($rose(busWake) |-> canRx && !drvDominant)
    else $error("wake while active");
  a_wake_sticky: assert property ($fell(busWake) |-> sinceWr <= MODE_WIN)
    else $error("wake flag dropped");
  a_slew_write: assert property ($changed(slewSel) |-> sinceWr == 1)
    else $error("slew changed alone");
  a_lowpwr_quiet: assert property (s_lowWr |-> ##3 (canRx && !drvDominant))
    else $error("line active outside normal mode");
endmodule
bind cwl_line_control cwl_line_checker #(.DOM_TO(DOM_TO), .MODE_DLY(MODE_DLY)) u_chk(.clk_sys(clk_sys), .sys_rst(sys_rst),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hsel(hsel), .hready(hready),
  .canTx(canTx), .canRx(canRx), .busDominant(busDominant), .drvDominant(drvDominant),
  .slewSel(slewSel), .busWake(busWake));

// [bench/tb.sv]
`timescale 1ns/10ps
module tb
  import cwl_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, hwrite = 0, canTx = 1, extDom = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0, slewSel;
  logic hsel = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, canRx, busDominant, wakeBusDominant, drvDominant, busWake, irq;
  int compares = 0, miscompares = 0;
  // mode, tx, other node, expected drive, expected rx
  logic [5:0] rows [4] = '{6'b010001, 6'b100010, 6'b101100, 6'b101001};
  cwl_line_control #(.MODE_DLY(20), .DOM_TO(100), .FILT_MAX(200), .WAKE_TO(200)) u_dut(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .canTx(canTx), .canRx(canRx), .busDominant(busDominant),
    .wakeBusDominant(wakeBusDominant), .drvDominant(drvDominant), .slewSel(slewSel),
    .busWake(busWake), .irq(irq));
  cwl_bus_model u_bus(.drvDominant(drvDominant), .extDom(extDom), .busDominant(busDominant),
    .wakeBusDominant(wakeBusDominant));
  initial forever #20 clk_sys = ~clk_sys;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic pulse(input int w);
    extDom <= 1;
    repeat (w) @(posedge clk_sys);
    extDom <= 0;
    repeat (30) @(posedge clk_sys);
  endtask
  task tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      xfer(1, CWL_OFF_CTRL, {26'h0, 2'h3, 2'h1, rows[i][5:4]});
      canTx <= rows[i][3];
      extDom <= rows[i][2];
      // long enough for the shortened mode switch
      repeat (30) @(posedge clk_sys);
      chk("line", rows[i][1:0], {drvDominant, canRx});
    end
    $display("test lines done");
    canTx <= 0;
    repeat (120) @(posedge clk_sys);
    chk("domto", 0, drvDominant);
    canTx <= 1;
    chk("slew", 3, slewSel);
    xfer(0, 8'h10, 32'h0);
    chk("unmapped", 0, q);
    chk("okay", 0, hresp);
    xfer(1, CWL_OFF_CTRL, 32'h0);
    repeat (3) pulse(20);
    chk("wakeoff", 0, busWake);
    xfer(1, CWL_OFF_CTRL, 32'h4);
    xfer(1, CWL_OFF_MASK, 32'h7);
    xfer(0, CWL_OFF_IRQ, 32'h0);
    repeat (2) pulse(20);
    pulse(5);
    repeat (2) pulse(20);
    chk("short", 0, busWake);
    repeat (210) @(posedge clk_sys);
    repeat (2) pulse(20);
    chk("gap", 0, busWake);
    pulse(20);
    chk("wake", 1, busWake);
    chk("irq", 1, irq);
    xfer(0, CWL_OFF_IRQ, 32'h0);
    chk("irqstat", 1, q[0]);
    @(posedge clk_sys);
    chk("irqclr", 0, irq);
    chk("held", 1, busWake);
    xfer(1, CWL_OFF_CTRL, 32'h6);
    repeat (30) @(posedge clk_sys);
    chk("wakeclr", 0, busWake);
    chk("irqmode", 1, irq);
    xfer(1, CWL_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("masked", 0, irq);
    $display("test wake done");
    xfer(1, CWL_OFF_CTRL, 32'h26);
    sys_rst <= 1;
    repeat (2) @(posedge clk_sys);
    chk("rstslew", 0, slewSel);
    sys_rst <= 0;
    @(posedge clk_sys);
    xfer(0, CWL_OFF_CTRL, 32'h0);
    chk("rstctrl", CWL_CTRL_RESET, q);
    $display("test reset done");
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish;
  end
endmodule
